// ==== design/irq_source_priority_bank.sv ====
/*
  Priority bank for normal interrupt sources: two priority registers, vectored enable,
  priority resolution over fifteen sources and an eight level nesting record.
  Assumes an AXI4-Lite master, one clock, and that the core pulses taken and done once
  per entry and exit of an interrupt service routine.
*/
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
`include "irq_prio_params.svh"
// Operation
// R1: The first register holds 3-bit levels for timer 3 [22:20], timer 2 [18:16], timer 1 [14:12] and timer 0 [10:8].
// R2: The first register holds the second flash block level in bits 30 to 28.
// R3: The first register holds the first flash block level in bits 26 to 24.
// R4: The first register holds the software interrupt level in bits 6 to 4.
// R5: Source 0 has no level and bits 3 to 0 of the first register assign nothing.
// R6: The second register holds the second two-wire slave level [30:28] and master level [26:24].
// R7: The second register holds the first two-wire slave level [22:20] and master level [18:16].
// R8: The second register holds the clock lock level in bits 14 to 12.
// R9: The second register holds the second serial port level [10:8] and the first [6:4].
// R10: The second register holds the converter level in bits 2 to 0.
// R11: Reset clears every field of both registers to zero.
// R12: Every field takes any level 0 to 7 and both registers are read and written by software.
// R13: With vectored handling on, normal interrupts nest by level up to eight levels deep.
// R14: Software sets bit 0 of the vectored control register to turn on vectored handling.
// R15: Reserved bits read as zero and ignore writes.
// R16: Field values drive the resolution logic continuously and a write acts from the next cycle.
module irq_source_priority_bank
(
  input logic clk,
  input logic rst_b,
  input logic ce,
  input logic [31:0] awaddr,
  input logic [2:0] awprot,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  input logic [31:0] araddr,
  input logic [2:0] arprot,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  input logic [14:0] irqSrcReq,
  input logic irqTaken,
  input logic irqDone,
  output logic irqRequest,
  output logic [3:0] irqSource,
  output logic [2:0] irqLevel,
  output logic vectoredEnable,
  output logic [2:0] flashBlock1Priority,
  output logic [2:0] flashBlock0Priority,
  output logic [2:0] timer3Priority,
  output logic [2:0] timer2Priority,
  output logic [2:0] timer1Priority,
  output logic [2:0] timer0Priority,
  output logic [2:0] softIrqPriority,
  output logic [2:0] twowire1SlavePriority,
  output logic [2:0] twowire1MasterPriority,
  output logic [2:0] twowire0SlavePriority,
  output logic [2:0] twowire0MasterPriority,
  output logic [2:0] clockLockPriority,
  output logic [2:0] serialPort1Priority,
  output logic [2:0] serialPort0Priority,
  output logic [2:0] converterPriority
);
  irq_prio_pkg::bank_state_t s_q;
  irq_prio_pkg::bank_state_t s_d;
  reg_access_if regBus();

  logic [14:0][2:0] srcLvl;
  logic anyPend;
  logic [2:0] bestLvl;
  logic [3:0] bestSrc;
  logic [2:0] curLvl;
  logic nestActive;
  logic [7:0] lowBit;
  logic [7:0] nextMask;
  logic [31:0] rdWord;

  axil_front front
  (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .bus(regBus)
  );

  // Byte lanes merged, then reserved positions forced to zero
  function automatic logic [31:0] mergeWrite(input logic [31:0] oldV, input logic [31:0] newV,
    input logic [3:0] strb, input logic [31:0] keep);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return ((oldV & ~m) | (newV & m)) & keep;
  endfunction

  // Field extraction: the bank flops feed resolution directly, no shadow copy
  assign srcLvl[`SRC_FLASH1] = s_q.prioTimersFlash[`FLD_FLASH1 +: `FLD_W]; // [R2] [R16]
  assign srcLvl[`SRC_FLASH0] = s_q.prioTimersFlash[`FLD_FLASH0 +: `FLD_W]; // [R3]
  assign srcLvl[`SRC_TIMER3] = s_q.prioTimersFlash[`FLD_TIMER3 +: `FLD_W]; // [R1]
  assign srcLvl[`SRC_TIMER2] = s_q.prioTimersFlash[`FLD_TIMER2 +: `FLD_W]; // [R1]
  assign srcLvl[`SRC_TIMER1] = s_q.prioTimersFlash[`FLD_TIMER1 +: `FLD_W]; // [R1]
  assign srcLvl[`SRC_TIMER0] = s_q.prioTimersFlash[`FLD_TIMER0 +: `FLD_W]; // [R1]
  assign srcLvl[`SRC_SOFT] = s_q.prioTimersFlash[`FLD_SOFT +: `FLD_W]; // [R4]
  assign srcLvl[`SRC_TW1_SLAVE] = s_q.prioSerialMisc[`FLD_TW1_SLAVE +: `FLD_W]; // [R6]
  assign srcLvl[`SRC_TW1_MASTER] = s_q.prioSerialMisc[`FLD_TW1_MASTER +: `FLD_W]; // [R6]
  assign srcLvl[`SRC_TW0_SLAVE] = s_q.prioSerialMisc[`FLD_TW0_SLAVE +: `FLD_W]; // [R7]
  assign srcLvl[`SRC_TW0_MASTER] = s_q.prioSerialMisc[`FLD_TW0_MASTER +: `FLD_W]; // [R7]
  assign srcLvl[`SRC_LOCK] = s_q.prioSerialMisc[`FLD_LOCK +: `FLD_W]; // [R8]
  assign srcLvl[`SRC_SERIAL1] = s_q.prioSerialMisc[`FLD_SERIAL1 +: `FLD_W]; // [R9]
  assign srcLvl[`SRC_SERIAL0] = s_q.prioSerialMisc[`FLD_SERIAL0 +: `FLD_W]; // [R9]
  assign srcLvl[`SRC_CONV] = s_q.prioSerialMisc[`FLD_CONV +: `FLD_W]; // [R10]

  // Register reads; unmapped addresses answer SLVERR
  always_comb
  begin
    rdWord = 32'h00000000;
    regBus.rdErr = 1'b0;
    unique case (regBus.rdAddr)
      `ADDR_PRIO_TIMERS_FLASH: rdWord = s_q.prioTimersFlash; // [R12] [R15]
      `ADDR_PRIO_SERIAL_MISC: rdWord = s_q.prioSerialMisc; // [R12] [R15]
      `ADDR_VECTORED_CONTROL: rdWord[`VEC_EN_BIT] = s_q.vecEn;
      `ADDR_NEST_STATUS:
      begin
        rdWord[`STAT_MASK_LSB +: `NEST_LEVELS] = s_q.activeMask;
        rdWord[`STAT_CUR_LSB +: `FLD_W] = curLvl;
        rdWord[`STAT_NEST_BIT] = nestActive;
      end
      default: regBus.rdErr = 1'b1;
    endcase
    regBus.rdData = rdWord;
  end

  always_comb
  begin
    regBus.wrErr = !(regBus.wrAddr == `ADDR_PRIO_TIMERS_FLASH ||
      regBus.wrAddr == `ADDR_PRIO_SERIAL_MISC ||
      regBus.wrAddr == `ADDR_VECTORED_CONTROL ||
      regBus.wrAddr == `ADDR_NEST_STATUS);
  end

  // Resolution: lowest level value wins, ties go to the lower source index
  always_comb
  begin
    anyPend = 1'b0;
    bestLvl = `LEVEL_LOWEST;
    bestSrc = 4'h0;
    for (int i = 0; i < `NUM_SRC; i++)
    begin
      if (irqSrcReq[i] && (!anyPend || srcLvl[i] < bestLvl)) // [R16]
      begin
        anyPend = 1'b1;
        bestLvl = srcLvl[i];
        bestSrc = 4'(i);
      end
    end
  end

  // Current nesting level is the most urgent level still in service
  always_comb
  begin
    curLvl = `LEVEL_LOWEST;
    for (int j = `NEST_LEVELS - 1; j >= 0; j--)
    begin
      if (s_q.activeMask[j])
        curLvl = 3'(j);
    end
    nestActive = |s_q.activeMask;
    lowBit = s_q.activeMask & (~s_q.activeMask + `ONE_LEVEL);
  end

  always_comb
  begin
    s_d = s_q;
    nextMask = s_q.activeMask;
    if (regBus.wrEn)
    begin
      unique case (regBus.wrAddr)
        `ADDR_PRIO_TIMERS_FLASH: s_d.prioTimersFlash = mergeWrite(s_q.prioTimersFlash, // [R5] [R15]
          regBus.wrData, regBus.wrStrb, `MASK_TIMERS_FLASH);
        `ADDR_PRIO_SERIAL_MISC: s_d.prioSerialMisc = mergeWrite(s_q.prioSerialMisc, // [R12] [R15]
          regBus.wrData, regBus.wrStrb, `MASK_SERIAL_MISC);
        `ADDR_VECTORED_CONTROL:
        begin
          if (regBus.wrStrb[0])
            s_d.vecEn = regBus.wrData[`VEC_EN_BIT]; // [R14]
        end
        default:
        begin
        end
      endcase
    end
    // Done retires the most urgent level; taken then records the granted level.
    // Taken without a standing request is ignored so a stray pulse cannot corrupt the record.
    if (s_q.vecEn)
    begin
      if (irqDone)
        nextMask = nextMask & ~lowBit; // [R13]
      if (irqTaken && s_q.irqReq)
        nextMask = nextMask | (`ONE_LEVEL << s_q.irqLvl); // [R13]
    end
    s_d.activeMask = nextMask;
    // Vectored: only a strictly more urgent level preempts; otherwise any pending source
    if (s_q.vecEn) // [R14]
      s_d.irqReq = anyPend && (!nestActive || bestLvl < curLvl); // [R13]
    else
      s_d.irqReq = anyPend;
    s_d.irqSrc = bestSrc;
    s_d.irqLvl = bestLvl;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      s_q <= '0; // [R11]
    else if (ce)
      s_q <= s_d;
  end

  assign irqRequest = s_q.irqReq;
  assign irqSource = s_q.irqSrc;
  assign irqLevel = s_q.irqLvl;
  assign vectoredEnable = s_q.vecEn;
  assign flashBlock1Priority = srcLvl[`SRC_FLASH1];
  assign flashBlock0Priority = srcLvl[`SRC_FLASH0];
  assign timer3Priority = srcLvl[`SRC_TIMER3];
  assign timer2Priority = srcLvl[`SRC_TIMER2];
  assign timer1Priority = srcLvl[`SRC_TIMER1];
  assign timer0Priority = srcLvl[`SRC_TIMER0];
  assign softIrqPriority = srcLvl[`SRC_SOFT];
  assign twowire1SlavePriority = srcLvl[`SRC_TW1_SLAVE];
  assign twowire1MasterPriority = srcLvl[`SRC_TW1_MASTER];
  assign twowire0SlavePriority = srcLvl[`SRC_TW0_SLAVE];
  assign twowire0MasterPriority = srcLvl[`SRC_TW0_MASTER];
  assign clockLockPriority = srcLvl[`SRC_LOCK];
  assign serialPort1Priority = srcLvl[`SRC_SERIAL1];
  assign serialPort0Priority = srcLvl[`SRC_SERIAL0];
  assign converterPriority = srcLvl[`SRC_CONV];

  a_reset_clear: assert property (@(posedge clk) // [R11]
    !rst_b |-> (s_q.prioTimersFlash == `PRIO_RESET && s_q.prioSerialMisc == `PRIO_RESET))
    else $error("priority registers not zero in reset");

  a_source0_empty: assert property (@(posedge clk) disable iff (!rst_b) // [R5] [R15]
    (s_q.prioTimersFlash[`FLD_SOURCE0 +: `FLD_SOURCE0_W] == 4'h0)
    && ((s_q.prioTimersFlash & ~`MASK_TIMERS_FLASH) == 32'h00000000)
    && ((s_q.prioSerialMisc & ~`MASK_SERIAL_MISC) == 32'h00000000))
    else $error("reserved priority bits not zero");

  a_write_timers: assert property (@(posedge clk) disable iff (!rst_b) // [R1] [R2] [R3] [R4]
    (ce && regBus.wrEn && regBus.wrAddr == `ADDR_PRIO_TIMERS_FLASH && regBus.wrStrb == 4'hF)
    |=> (timer2Priority == $past(regBus.wrData[`FLD_TIMER2 +: `FLD_W]))
    && (s_q.prioTimersFlash == ($past(regBus.wrData) & `MASK_TIMERS_FLASH)))
    else $error("first priority register write not stored");

  a_write_serial: assert property (@(posedge clk) disable iff (!rst_b) // [R6] [R7] [R8] [R9] [R10]
    (ce && regBus.wrEn && regBus.wrAddr == `ADDR_PRIO_SERIAL_MISC && regBus.wrStrb == 4'hF)
    |=> (converterPriority == $past(regBus.wrData[`FLD_CONV +: `FLD_W]))
    && (s_q.prioSerialMisc == ($past(regBus.wrData) & `MASK_SERIAL_MISC)))
    else $error("second priority register write not stored");

  a_read_back: assert property (@(posedge clk) disable iff (!rst_b) // [R12]
    (ce && regBus.rdEn && regBus.rdAddr == `ADDR_PRIO_SERIAL_MISC)
    |=> (rvalid && rresp == `RESP_OKAY && rdata == $past(s_q.prioSerialMisc)))
    else $error("second priority register read mismatch");

  a_field_live: assert property (@(posedge clk) disable iff (!rst_b) // [R16]
    (ce && irqSrcReq == 15'h0008 && !s_q.vecEn) |=> (irqRequest && irqSource == 4'h3
    && irqLevel == $past(timer2Priority)))
    else $error("resolution does not follow the live field value");

  a_nest_hold: assert property (@(posedge clk) disable iff (!rst_b) // [R13]
    (ce && s_q.vecEn && nestActive && (!anyPend || bestLvl >= curLvl)) |=> !irqRequest)
    else $error("request raised without a more urgent level");

  a_nest_push: assert property (@(posedge clk) disable iff (!rst_b) // [R13]
    (ce && s_q.vecEn && irqTaken && s_q.irqReq && !irqDone)
    |=> s_q.activeMask[$past(s_q.irqLvl)])
    else $error("taken interrupt level not recorded");
endmodule

// ==== design/irq_prio_params.svh ====
/*
  Named constants of the interrupt source priority bank: register byte addresses,
  field positions, masks, reset values, source indices and bus answers.
  Assumes it is included by its bare name from any file that needs these numbers.
*/
`ifndef IRQ_PRIO_PARAMS_SVH
`define IRQ_PRIO_PARAMS_SVH

`define ADDR_PRIO_TIMERS_FLASH 32'hFFFF0020
`define ADDR_PRIO_SERIAL_MISC 32'hFFFF0024
`define ADDR_VECTORED_CONTROL 32'hFFFF0040
`define ADDR_NEST_STATUS 32'hFFFF0044

`define PRIO_RESET 32'h00000000
`define MASK_TIMERS_FLASH 32'h77777770
`define MASK_SERIAL_MISC 32'h77777777
`define FLD_W 3

`define FLD_FLASH1 28
`define FLD_FLASH0 24
`define FLD_TIMER3 20
`define FLD_TIMER2 16
`define FLD_TIMER1 12
`define FLD_TIMER0 8
`define FLD_SOFT 4
`define FLD_SOURCE0 0
`define FLD_SOURCE0_W 4

`define FLD_TW1_SLAVE 28
`define FLD_TW1_MASTER 24
`define FLD_TW0_SLAVE 20
`define FLD_TW0_MASTER 16
`define FLD_LOCK 12
`define FLD_SERIAL1 8
`define FLD_SERIAL0 4
`define FLD_CONV 0

`define VEC_EN_BIT 0
`define STAT_MASK_LSB 0
`define STAT_CUR_LSB 8
`define STAT_NEST_BIT 11

`define NUM_SRC 15
`define NEST_LEVELS 8
`define LEVEL_LOWEST 3'h7
`define ONE_LEVEL 8'h01

`define SRC_FLASH1 0
`define SRC_FLASH0 1
`define SRC_TIMER3 2
`define SRC_TIMER2 3
`define SRC_TIMER1 4
`define SRC_TIMER0 5
`define SRC_SOFT 6
`define SRC_TW1_SLAVE 7
`define SRC_TW1_MASTER 8
`define SRC_TW0_SLAVE 9
`define SRC_TW0_MASTER 10
`define SRC_LOCK 11
`define SRC_SERIAL1 12
`define SRC_SERIAL0 13
`define SRC_CONV 14

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== design/irq_prio_pkg.sv ====
/*
  Types shared by the priority bank and its bus front end.
  Assumes the constants header supplies every number.
*/
package irq_prio_pkg;

  typedef struct packed {
    logic [31:0] prioTimersFlash;
    logic [31:0] prioSerialMisc;
    logic vecEn;
    logic [7:0] activeMask;
    logic irqReq;
    logic [3:0] irqSrc;
    logic [2:0] irqLvl;
  } bank_state_t;

  typedef struct packed {
    logic awHeld;
    logic wHeld;
    logic [31:0] wAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awRdy;
    logic wRdy;
    logic bValid;
    logic [1:0] bResp;
    logic arRdy;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } axil_state_t;

endpackage

// ==== design/reg_access_if.sv ====
/*
  Internal register access strobes between the bus front end and the register bank.
  Assumes read data and error answers are combinational from the bank.
*/
`timescale 1ns/10ps
interface reg_access_if;
  logic wrEn;
  logic [31:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic wrErr;
  logic rdEn;
  logic [31:0] rdAddr;
  logic [31:0] rdData;
  logic rdErr;

  modport front
  (
    output wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr,
    input wrErr, rdData, rdErr
  );

  modport bank
  (
    input wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr,
    output wrErr, rdData, rdErr
  );
endinterface

// ==== design/axil_front.sv ====
/*
  AXI4-Lite slave front end: takes write address and data in either order, issues one
  write strobe, answers with a response; takes one read at a time.
  Assumes clock enable stays high while the bus master is active.
*/
`timescale 1ns/10ps
`include "irq_prio_params.svh"
module axil_front
(
  input logic clk,
  input logic rst_b,
  input logic ce,
  input logic [31:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  input logic [31:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  reg_access_if.front bus
);
  irq_prio_pkg::axil_state_t s_q;
  irq_prio_pkg::axil_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    bus.wrEn = 1'b0;
    bus.wrAddr = s_q.wAddr;
    bus.wrData = s_q.wData;
    bus.wrStrb = s_q.wStrb;
    bus.rdEn = arvalid && s_q.arRdy;
    bus.rdAddr = araddr;
    if (awvalid && s_q.awRdy)
    begin
      s_d.awHeld = 1'b1;
      s_d.wAddr = awaddr;
    end
    if (wvalid && s_q.wRdy)
    begin
      s_d.wHeld = 1'b1;
      s_d.wData = wdata;
      s_d.wStrb = wstrb;
    end
    if (s_q.bValid && bready)
      s_d.bValid = 1'b0;
    // Both halves held and no response pending: one write strobe
    if (s_q.awHeld && s_q.wHeld && !s_q.bValid)
    begin
      bus.wrEn = 1'b1;
      s_d.awHeld = 1'b0;
      s_d.wHeld = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp = bus.wrErr ? `RESP_SLVERR : `RESP_OKAY;
    end
    if (s_q.rValid && rready)
      s_d.rValid = 1'b0;
    if (bus.rdEn)
    begin
      s_d.rValid = 1'b1;
      s_d.rData = bus.rdData;
      s_d.rResp = bus.rdErr ? `RESP_SLVERR : `RESP_OKAY;
    end
    // Readies stall until the pending response is taken, one write and one read at a time
    s_d.awRdy = !s_d.awHeld && !s_d.bValid;
    s_d.wRdy = !s_d.wHeld && !s_d.bValid;
    s_d.arRdy = !s_d.rValid;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      s_q <= '0;
    else if (ce)
      s_q <= s_d;
  end

  assign awready = s_q.awRdy;
  assign wready = s_q.wRdy;
  assign bvalid = s_q.bValid;
  assign bresp = s_q.bResp;
  assign arready = s_q.arRdy;
  assign rvalid = s_q.rValid;
  assign rdata = s_q.rData;
  assign rresp = s_q.rResp;

  a_write_answer: assert property (@(posedge clk) disable iff (!rst_b) // [R12]
    (ce && s_q.awHeld && s_q.wHeld && !s_q.bValid) |=> (bvalid && !awready && !wready))
    else $error("write not answered one cycle after both halves held");
endmodule

// ==== tb/irq_source_priority_bank_tb_top.sv ====
/*
  Self-checking bench for the interrupt source priority bank: register traffic over
  AXI4-Lite, priority outputs, nesting requests and a second reset in mid-run.
  Assumes the design files and the constants header are compiled before it.
*/
`timescale 1ns/10ps
`include "irq_prio_params.svh"
module irq_source_priority_bank_tb_top;
  typedef struct {
    string name;
    logic [33:0] val;
  } exp_t;
  logic clk = 1'b0;
  logic rst_b;
  logic ce = 1'b1;
  logic [31:0] awaddr = 32'h00000000;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] araddr = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [14:0] irqSrcReq = 15'h0000;
  logic irqTaken = 1'b0;
  logic irqDone = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irqRequest, vectoredEnable;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] irqSource;
  logic [2:0] irqLevel;
  logic [2:0] prio [15];
  exp_t expQ [$];
  int failCount = 0;
  int cmpCount = 0;
  logic [31:0] m [2];
  logic [31:0] mask [2];
  logic [31:0] addrTab [2];
  int lsbTab [15] = '{28, 24, 20, 16, 12, 8, 4, 28, 24, 20, 16, 12, 8, 4, 0};

  irq_source_priority_bank i_irq_source_priority_bank
  (
    .clk(clk), .rst_b(rst_b), .ce(ce), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irqSrcReq(irqSrcReq), .irqTaken(irqTaken), .irqDone(irqDone),
    .irqRequest(irqRequest), .irqSource(irqSource), .irqLevel(irqLevel),
    .vectoredEnable(vectoredEnable), .flashBlock1Priority(prio[0]),
    .flashBlock0Priority(prio[1]), .timer3Priority(prio[2]), .timer2Priority(prio[3]),
    .timer1Priority(prio[4]), .timer0Priority(prio[5]), .softIrqPriority(prio[6]),
    .twowire1SlavePriority(prio[7]), .twowire1MasterPriority(prio[8]),
    .twowire0SlavePriority(prio[9]), .twowire0MasterPriority(prio[10]),
    .clockLockPriority(prio[11]), .serialPort1Priority(prio[12]),
    .serialPort0Priority(prio[13]), .converterPriority(prio[14])
  );

  always #5 clk = ~clk;

  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    cmpCount++;
    if (g !== e)
    begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic popChk(input logic [33:0] g);
    exp_t e;
    if (expQ.size() == 0)
    begin
      failCount++;
      $display("[FAIL] bus answer expected none seen %h", g);
    end
    else
    begin
      e = expQ.pop_front();
      chk(e.name, e.val, g);
    end
  endtask

  // Values seen at the falling edge are what the next rising edge samples
  always @(negedge clk)
  begin
    if (rvalid === 1'b1 && rready === 1'b1)
      popChk({rresp, rdata});
    if (bvalid === 1'b1 && bready === 1'b1)
      popChk({bresp, 32'h00000000});
  end

  task automatic axiWrite(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] r);
    logic hitA, hitW, aDone, wDone, hitB;
    expQ.push_back('{"write response", {r, 32'h00000000}});
    aDone = 1'b0;
    wDone = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge clk);
      hitA = awvalid && awready;
      hitW = wvalid && wready;
      @(posedge clk);
      if (hitA)
      begin
        awvalid <= 1'b0;
        aDone = 1'b1;
      end
      if (hitW)
      begin
        wvalid <= 1'b0;
        wDone = 1'b1;
      end
    end while (!(aDone && wDone));
    do
    begin
      @(negedge clk);
      hitB = bvalid;
      @(posedge clk);
    end while (!hitB);
    bready <= 1'b0;
  endtask

  task automatic axiRead(input logic [31:0] a, d, input logic [1:0] r);
    logic hit;
    expQ.push_back('{"read data", {r, d}});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge clk);
      hit = arready;
      @(posedge clk);
    end while (!hit);
    arvalid <= 1'b0;
    do
    begin
      @(negedge clk);
      hit = rvalid;
      @(posedge clk);
    end while (!hit);
    rready <= 1'b0;
  endtask

  task automatic checkOuts();
    @(negedge clk);
    for (int j = 0; j < 15; j++)
      chk("priority output", {31'h0, m[j < 7 ? 0 : 1][lsbTab[j] +: 3]}, {31'h0, prio[j]});
  endtask

  // Model keeps byte lanes and drops reserved bits, like the bank must
  task automatic setReg(input int r, input logic [31:0] d, input logic [3:0] s);
    for (int b = 0; b < 4; b++)
      if (s[b])
        m[r][8 * b +: 8] = d[8 * b +: 8];
    m[r] = m[r] & mask[r];
    axiWrite(addrTab[r], d, s, `RESP_OKAY);
    checkOuts();
  endtask

  task automatic fieldWrite(input int i, input logic [2:0] lv);
    int r;
    logic [31:0] d;
    r = i < 7 ? 0 : 1;
    d = m[r];
    d[lsbTab[i] +: 3] = lv;
    d = d | ($urandom() & ~mask[r]);
    setReg(r, d, 4'hF);
    axiRead(addrTab[r], m[r], `RESP_OKAY);
  endtask

  task automatic checkIrq(input logic q, input logic [3:0] s, input logic [2:0] l);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("irq request", {33'h0, q}, {33'h0, irqRequest});
    chk("irq source", {30'h0, s}, {30'h0, irqSource});
    chk("irq level", {31'h0, l}, {31'h0, irqLevel});
  endtask

  task automatic pulse(input logic done);
    @(posedge clk);
    if (done)
      irqDone <= 1'b1;
    else
      irqTaken <= 1'b1;
    @(posedge clk);
    irqDone <= 1'b0;
    irqTaken <= 1'b0;
  endtask

  task automatic doReset();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    m = '{32'h00000000, 32'h00000000};
  endtask

  task automatic endTest(input string n);
    $display("test %s done", n);
  endtask

  task automatic completeRun();
    $display("comparisons %0d mismatches %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0 && expQ.size() == 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Whole run is a few hundred cycles; this limit leaves ample margin
  initial
  begin
    repeat (50000) @(posedge clk);
    failCount++;
    $display("[FAIL] run end expected before limit seen timeout");
    completeRun();
  end

  initial
  begin
    // X to 0 at time zero is a falling edge, so state is cleared before the first clock
    rst_b <= 1'b0;
    void'($urandom(32'h8704));
    mask = '{`MASK_TIMERS_FLASH, `MASK_SERIAL_MISC};
    addrTab = '{`ADDR_PRIO_TIMERS_FLASH, `ADDR_PRIO_SERIAL_MISC};
    doReset();
    axiRead(`ADDR_PRIO_TIMERS_FLASH, `PRIO_RESET, `RESP_OKAY);
    axiRead(`ADDR_PRIO_SERIAL_MISC, `PRIO_RESET, `RESP_OKAY);
    checkOuts();
    endTest("reset values");
    for (int i = 0; i < 15; i++)
      fieldWrite(i, 3'h7);
    for (int i = 0; i < 15; i++)
      fieldWrite(i, 3'($urandom() % 8));
    for (int i = 0; i < 15; i++)
      fieldWrite(i, 3'h0);
    endTest("field walk");
    setReg(0, 32'hFFFFFFFF, 4'hF);
    setReg(1, 32'hFFFFFFFF, 4'hF);
    setReg(1, 32'h00000000, 4'h2);
    setReg(0, 32'h0000000F, 4'h1);
    axiRead(`ADDR_PRIO_TIMERS_FLASH, m[0], `RESP_OKAY);
    axiRead(`ADDR_PRIO_SERIAL_MISC, m[1], `RESP_OKAY);
    endTest("byte lanes and reserved bits");
    axiWrite(32'hFFFF0030, 32'hFFFFFFFF, 4'hF, `RESP_SLVERR);
    axiRead(32'hFFFF0030, 32'h00000000, `RESP_SLVERR);
    axiRead(`ADDR_PRIO_SERIAL_MISC, m[1], `RESP_OKAY);
    endTest("unmapped address");
    setReg(0, 32'h00020000, 4'hF);
    setReg(1, 32'h00000001, 4'hF);
    axiWrite(`ADDR_VECTORED_CONTROL, 32'h00000001, 4'hF, `RESP_OKAY);
    @(negedge clk);
    chk("vectored enable", 34'h1, {33'h0, vectoredEnable});
    @(posedge clk);
    irqSrcReq <= 15'h0008;
    checkIrq(1'b1, 4'h3, 3'h2);
    pulse(1'b0);
    checkIrq(1'b0, 4'h3, 3'h2);
    axiRead(`ADDR_NEST_STATUS, 32'h00000A04, `RESP_OKAY);
    @(posedge clk);
    irqSrcReq <= 15'h4008;
    checkIrq(1'b1, 4'hE, 3'h1);
    pulse(1'b1);
    checkIrq(1'b1, 4'hE, 3'h1);
    axiRead(`ADDR_NEST_STATUS, 32'h00000700, `RESP_OKAY);
    @(posedge clk);
    irqSrcReq <= 15'h0000;
    endTest("nesting");
    setReg(1, 32'h77777777, 4'hF);
    doReset();
    axiRead(`ADDR_PRIO_TIMERS_FLASH, `PRIO_RESET, `RESP_OKAY);
    axiRead(`ADDR_PRIO_SERIAL_MISC, `PRIO_RESET, `RESP_OKAY);
    checkOuts();
    chk("vectored enable", 34'h0, {33'h0, vectoredEnable});
    endTest("second reset");
    // Plain mode: any pending source requests and taken leaves no nesting record
    @(posedge clk);
    irqSrcReq <= 15'h0008;
    checkIrq(1'b1, 4'h3, 3'h0);
    pulse(1'b0);
    axiRead(`ADDR_NEST_STATUS, 32'h00000700, `RESP_OKAY);
    // Bus idle here; clock enable low must freeze the request outputs
    @(posedge clk);
    ce <= 1'b0;
    irqSrcReq <= 15'h0000;
    checkIrq(1'b1, 4'h3, 3'h0);
    @(posedge clk);
    ce <= 1'b1;
    checkIrq(1'b0, 4'h0, 3'h7);
    endTest("plain mode and clock enable");
    repeat (2) @(posedge clk);
    completeRun();
  end
endmodule
